// >>> rtl/meter_defines.svh
`ifndef METER_DEFINES_SVH
`define METER_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL    8'h00
`define OFS_CMD     8'h04
`define OFS_RXDATA  8'h08
`define OFS_STATUS  8'h0C
`define OFS_MASK    8'h10
`define OFS_STATE   8'h14
`define OFS_RES_LO  8'h18
`define OFS_RES_HI  8'h1C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_WAIT   2
`define CTRL_AMP    3
`define CMD_CODE    0
`define CMD_RESET   1
`define EV_RX       0
`define EV_DONE     1
`define EV_TRIG     2
// ----------------------------------------
// Sample setting codes and reset values
// ----------------------------------------
`define SMP_PANEL   2'h0
`define SMP_HOLD    2'h1
`define SMP_FAST    2'h2
`define SMP_SHOLD   2'h3
`define EXP_RST     8'h06
`define FUNC_RST    8'h46
// ----------------------------------------
// Record characters and tail positions
// ----------------------------------------
`define CH_SP       8'h20
`define CH_DOT      8'h2E
`define CH_E        8'h45
`define CH_PLUS     8'h2B
`define CH_MINUS    8'h2D
`define CH_COMMA    8'h2C
`define CH_A        8'h41
`define CH_9        8'h39
`define CH_CR       8'h0D
`define CH_LF       8'h0A
`define TAIL_PLAIN  6'h15
`define TAIL_AMP    6'h1E
`endif

// >>> rtl/meter_pkg.sv
`default_nettype none
package meter_pkg;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    // Measurement sequence states, one-hot
    typedef enum logic [5:0] {
        ST_HELD = 6'h01,
        ST_MEAS = 6'h02,
        ST_SRQ  = 6'h04,
        ST_WAIT = 6'h08,
        ST_SEND = 6'h10,
        ST_NEXT = 6'h20
    } meas_state_t;
    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    // Instrument bus pins seen by the device
    typedef struct packed {
        logic       remote;
        logic       listen;
        logic       talk;
        logic       trig;
        logic       dav;
        logic       ack;
        logic [7:0] dio;
    } pins_t;
    // Result fields that build one record
    typedef struct packed {
        logic [7:0]  func;
        logic [43:0] mant;
        logic        exp_neg;
        logic [7:0]  exp;
        logic        amp_low;
    } result_t;
    // Whole state of the port
    typedef struct packed {
        pins_t       s1;
        pins_t       s2;
        pins_t       prev;
        meas_state_t state;
        logic [1:0]  sample;
        logic        wait_mode;
        logic        amp_on;
        logic [7:0]  rx_byte;
        logic        rx_full;
        logic [2:0]  sts;
        logic [2:0]  mask;
        result_t     res;
        logic [5:0]  idx;
        logic        tx_valid;
        logic        tx_last;
        logic [7:0]  tx_byte;
        logic        srq;
        logic        start;
        logic        blank;
        logic        irq;
        logic        remote_led;
        logic        recall_led;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } port_state_t;
endpackage : meter_pkg
`default_nettype wire

// >>> rtl/record_format.sv
`include "meter_defines.svh"
`default_nettype none
module record_format
(
    input  wire meter_pkg::result_t res_i,
    input  wire logic [5:0]         idx_i,
    output logic [7:0]              byte_o,
    output logic                    last_o
);
    import meter_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // BCD digit to ASCII
    function automatic logic [7:0] ascii_digit(input logic [3:0] d);
        return {4'h3, d};
    endfunction : ascii_digit

    // Mantissa digit k, most significant first
    function automatic logic [3:0] mant_digit(input logic [43:0] m, input logic [3:0] k);
        logic [5:0] pos;
        pos = 6'((4'hA - k) * 4);
        return m[pos +: 4];
    endfunction : mant_digit

    logic [5:0] tail;    // Index of carriage return

    // ----------------------------------------
    // Byte select
    // ----------------------------------------
    // Fixed-length record, amplitude field only on low signal
    always_comb
    begin
        tail   = res_i.amp_low ? `TAIL_AMP : `TAIL_PLAIN;
        byte_o = `CH_SP;
        last_o = (idx_i == tail + 6'h01);
        if (idx_i == tail)
            byte_o = `CH_CR;
        else if (idx_i == tail + 6'h01)
            byte_o = `CH_LF;
        else
        begin
            case (idx_i)
                6'h01: byte_o = res_i.func;
                6'h04, 6'h05, 6'h06, 6'h07, 6'h08:
                    byte_o = ascii_digit(mant_digit(res_i.mant, 4'(idx_i - 6'h04)));
                6'h09: byte_o = `CH_DOT;
                6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F:
                    byte_o = ascii_digit(mant_digit(res_i.mant, 4'(idx_i - 6'h05)));
                6'h10: byte_o = `CH_E;
                6'h11: byte_o = res_i.exp_neg ? `CH_MINUS : `CH_PLUS;
                6'h12: byte_o = ascii_digit(res_i.exp[7:4]);
                6'h13: byte_o = ascii_digit(res_i.exp[3:0]);
                6'h14: byte_o = `CH_COMMA;
                6'h15: byte_o = `CH_A;
                6'h17: byte_o = `CH_PLUS;
                6'h18, 6'h19, 6'h1B: byte_o = `CH_9;
                6'h1A: byte_o = `CH_DOT;
                6'h1C: byte_o = `CH_E;
                6'h1D: byte_o = `CH_PLUS;
                default: byte_o = `CH_SP;
            endcase
        end
    end
endmodule : record_format
`default_nettype wire

// >>> rtl/remote_port.sv
// Behaviour
// - Listening trigger forces sample-hold except in hold, starts measurement
// - Two output modes: if addressed, wait for talk
// - Reset code blanks display, restarts, stays remote
// - Reset in hold aborts measurement, stays held
// - If-addressed: SRQ, test talk, else release, restart
// - Talking: send record, release SRQ, then restart
// - Wait mode: SRQ and stall until talk
// - Each complete code executes like a keypress
// - Each received byte latched if the latch is free, processor interrupted
// - Partial code held until more bytes arrive
// - Complete code applied, measurement cycle restarted unless a record is being sent
// - Every further byte latched raises another interrupt
// - Results sent as fixed-length ASCII records
// - Low signal appends amplitude flag field
// - Remote indicator lit under remote control
// - Recall lamp lit while addressed to talk
`include "meter_defines.svh"
`default_nettype none
module remote_port
(
    input  wire logic                CLK_I,
    input  wire logic                RST_B_I,
    input  wire meter_pkg::apb_req_t APB_I,
    input  wire meter_pkg::pins_t    PINS_I,
    input  wire logic                MEAS_DONE_I,
    output logic                     PREADY_O,
    output logic                     PSLVERR_O,
    output logic [31:0]              PRDATA_O,
    output logic                     SRQ_O,
    output logic                     TX_VALID_O,
    output logic [7:0]               TX_BYTE_O,
    output logic                     RX_BUSY_O,
    output logic                     MEAS_START_O,
    output logic                     BLANK_O,
    output logic                     REMOTE_LED_O,
    output logic                     RECALL_LED_O,
    output logic                     IRQ_O
);
    import meter_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    port_state_t q;          // Registered state
    port_state_t n;          // Next state
    logic [7:0]  fmt_byte;   // Record byte at q.idx
    logic        fmt_last;   // That byte ends the record
    logic        access;     // APB access cycle taken
    logic        wr;         // Write access
    logic        rd;         // Read access
    logic        dav_rise;   // New byte strobe on the bus
    logic        trig_rise;  // Group trigger edge
    logic        trig_ok;    // Trigger addressed to us
    logic        code_go;    // Complete code executed
    logic        reset_go;   // Reset code executed
    logic [2:0]  ev;         // Events of this cycle
    logic [31:0] rdata;      // Read mux

    // ----------------------------------------
    // Record formatter
    // ----------------------------------------
    record_format u_fmt
    (
        .res_i  (q.res),
        .idx_i  (q.idx),
        .byte_o (fmt_byte),
        .last_o (fmt_last)
    );

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Pin sync, register file, byte latch, sequence
    always_comb
    begin
        n         = q;
        n.start   = 1'b0;
        n.blank   = 1'b0;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        n.prdata  = 32'h0000_0000;
        ev        = 3'h0;
        // Two-flop pin synchroniser, then edge history
        n.s1      = PINS_I;
        n.s2      = q.s1;
        n.prev    = q.s2;
        dav_rise  = q.s2.dav & ~q.prev.dav;
        trig_rise = q.s2.trig & ~q.prev.trig;
        trig_ok   = trig_rise & q.s2.remote & q.s2.listen;
        // One wait state, answer on the second access edge
        access    = APB_I.psel & APB_I.penable & ~q.pready;
        wr        = access & APB_I.pwrite;
        rd        = access & ~APB_I.pwrite;
        code_go   = wr & (APB_I.paddr == `OFS_CMD) & APB_I.pwdata[`CMD_CODE];
        reset_go  = wr & (APB_I.paddr == `OFS_CMD) & APB_I.pwdata[`CMD_RESET];

        // Byte latch, held until the processor reads it
        if (dav_rise && !q.rx_full)
        begin
            n.rx_byte   = q.s2.dio;
            n.rx_full   = 1'b1;
            ev[`EV_RX]  = 1'b1;
        end

        // Measurement sequence
        case (q.state)
            ST_HELD: n.state = ST_HELD;
            ST_MEAS:
            begin
                if (MEAS_DONE_I)
                begin
                    n.srq        = 1'b1;
                    n.state      = ST_SRQ;
                    ev[`EV_DONE] = 1'b1;
                end
            end
            ST_SRQ:
            begin
                // Test the talk address once
                if (q.s2.talk)
                    n.state = ST_SEND;
                else if (q.wait_mode)
                    n.state = ST_WAIT;
                else
                begin
                    n.srq   = 1'b0;
                    n.state = ST_NEXT;
                end
            end
            ST_WAIT:
            begin
                // Stall with SRQ until addressed to talk
                if (q.s2.talk)
                    n.state = ST_SEND;
            end
            ST_SEND:
            begin
                // Four-phase byte handshake with the bus
                if (q.tx_valid)
                begin
                    if (q.s2.ack)
                        n.tx_valid = 1'b0;
                end
                else if (!q.s2.ack)
                begin
                    if (q.tx_last)
                    begin
                        n.srq     = 1'b0;
                        n.tx_last = 1'b0;
                        n.state   = ST_NEXT;
                    end
                    else
                    begin
                        n.tx_byte  = fmt_byte;
                        n.tx_last  = fmt_last;
                        n.tx_valid = 1'b1;
                        n.idx      = q.idx + 6'h01;
                    end
                end
            end
            ST_NEXT:
            begin
                // Held settings wait for a trigger
                if (q.sample == `SMP_HOLD || q.sample == `SMP_SHOLD)
                    n.state = ST_HELD;
                else
                begin
                    n.start = 1'b1;
                    n.state = ST_MEAS;
                end
            end
            default: n.state = ST_HELD;
        endcase

        // Trigger outside a record in progress
        if (trig_ok && q.state != ST_SEND)
        begin
            if (q.sample != `SMP_HOLD)
                n.sample = `SMP_SHOLD;
            n.start      = 1'b1;
            n.srq        = 1'b0;
            n.state      = ST_MEAS;
            ev[`EV_TRIG] = 1'b1;
        end

        // Complete code restarts the cycle outside a record in progress
        if (code_go && q.state != ST_SEND)
        begin
            n.start = 1'b1;
            n.srq   = 1'b0;
            n.state = ST_MEAS;
        end

        // Reset code: blank and restart, hold aborts
        if (reset_go)
        begin
            n.blank    = 1'b1;
            n.start    = 1'b1;
            n.srq      = 1'b0;
            n.tx_valid = 1'b0;
            n.tx_last  = 1'b0;
            n.state    = (q.sample == `SMP_HOLD) ? ST_HELD : ST_MEAS;
        end

        // A record always starts from its first byte
        if (n.state == ST_SEND && q.state != ST_SEND)
        begin
            n.idx      = 6'h00;
            n.tx_last  = 1'b0;
            n.tx_valid = 1'b0;
        end

        // Register writes
        if (wr)
        begin
            case (APB_I.paddr)
                `OFS_CTRL:
                begin
                    n.sample    = APB_I.pwdata[1:0];
                    n.wait_mode = APB_I.pwdata[`CTRL_WAIT];
                    n.amp_on    = APB_I.pwdata[`CTRL_AMP];
                end
                `OFS_STATUS: n.sts = q.sts & ~APB_I.pwdata[2:0];
                `OFS_MASK: n.mask = APB_I.pwdata[2:0];
                `OFS_RES_LO: n.res.mant[31:0] = APB_I.pwdata;
                `OFS_RES_HI:
                begin
                    n.res.mant[43:32] = APB_I.pwdata[11:0];
                    n.res.exp         = APB_I.pwdata[19:12];
                    n.res.exp_neg     = APB_I.pwdata[20];
                    n.res.amp_low     = APB_I.pwdata[21] & q.amp_on;
                    n.res.func        = APB_I.pwdata[31:24];
                end
                `OFS_CMD, `OFS_RXDATA, `OFS_STATE: n.pslverr = 1'b0;
                default: n.pslverr = 1'b1;
            endcase
        end

        // Register reads
        rdata = 32'h0000_0000;
        case (APB_I.paddr)
            `OFS_CTRL:   rdata = {28'h0, q.amp_on, q.wait_mode, q.sample};
            `OFS_CMD:    rdata = 32'h0000_0000;
            `OFS_RXDATA: rdata = {24'h0, q.rx_byte};
            `OFS_STATUS: rdata = {29'h0, q.sts};
            `OFS_MASK:   rdata = {29'h0, q.mask};
            `OFS_STATE:  rdata = {20'h0, q.state, q.rx_full, q.srq,
                                  q.s2.talk, q.s2.listen, q.s2.remote, q.tx_valid};
            `OFS_RES_LO: rdata = q.res.mant[31:0];
            `OFS_RES_HI: rdata = {q.res.func, 2'h0, q.res.amp_low, q.res.exp_neg,
                                  q.res.exp, q.res.mant[43:32]};
            default:     rdata = 32'h0000_0000;
        endcase
        if (rd)
        begin
            n.prdata  = rdata;
            n.pslverr = (APB_I.paddr > `OFS_RES_HI) || (APB_I.paddr[1:0] != 2'h0);
            // Reading frees the latch, a byte landing now wins
            if (APB_I.paddr == `OFS_RXDATA && !ev[`EV_RX])
                n.rx_full = 1'b0;
        end
        if (access)
            n.pready = 1'b1;

        // Sticky events, set wins over clear
        n.sts = n.sts | ev;
        n.irq = |(n.sts & n.mask);

        // Indicators follow the synchronised bus state
        n.remote_led = q.s2.remote & q.prev.remote;
        n.recall_led = q.s2.talk & q.prev.talk;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Synchronous active-low reset
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            q         <= '0;
            q.state   <= ST_HELD;
            q.res.exp <= `EXP_RST;
            q.res.func <= `FUNC_RST;
        end
        else
            q <= n;
    end

    // ----------------------------------------
    // Outputs straight from flip-flops
    // ----------------------------------------
    assign PREADY_O     = q.pready;
    assign PSLVERR_O    = q.pslverr;
    assign PRDATA_O     = q.prdata;
    assign SRQ_O        = q.srq;
    assign TX_VALID_O   = q.tx_valid;
    assign TX_BYTE_O    = q.tx_byte;
    assign RX_BUSY_O    = q.rx_full;
    assign MEAS_START_O = q.start;
    assign BLANK_O      = q.blank;
    assign REMOTE_LED_O = q.remote_led;
    assign RECALL_LED_O = q.recall_led;
    assign IRQ_O        = q.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    trig_sets_hold_a: assert property (
        trig_ok && q.state != ST_SEND && q.sample != `SMP_HOLD && !wr
        |=> q.sample == `SMP_SHOLD && q.start && q.state == ST_MEAS)
        else $error("trigger did not start sample-hold measurement");

    reset_blank_a: assert property (
        reset_go |=> BLANK_O && MEAS_START_O && !SRQ_O ##1 !BLANK_O)
        else $error("reset code did not blank and restart");

    reset_hold_a: assert property (
        reset_go && q.sample == `SMP_HOLD && !trig_ok
        |=> q.state == ST_HELD)
        else $error("reset in hold left the held state");

    srq_release_a: assert property (
        q.state == ST_SRQ && !q.s2.talk && !q.wait_mode && !trig_ok && !code_go && !reset_go
        |=> !SRQ_O && q.state == ST_NEXT)
        else $error("unaddressed srq not released");

    send_order_a: assert property (
        $fell(SRQ_O) && $past(q.state) == ST_SEND && !$past(reset_go)
        |-> !TX_VALID_O && q.state == ST_NEXT)
        else $error("srq released before record finished");

    wait_stall_a: assert property (
        q.state == ST_WAIT && !q.s2.talk && !trig_ok && !code_go && !reset_go
        |=> q.state == ST_WAIT && SRQ_O)
        else $error("wait mode left without talk address");

    rx_latch_a: assert property (
        dav_rise && !q.rx_full
        |=> RX_BUSY_O && q.rx_byte == $past(q.s2.dio) && q.sts[`EV_RX])
        else $error("received byte not latched");

    rx_keep_a: assert property (
        q.rx_full && !(rd && APB_I.paddr == `OFS_RXDATA)
        |=> q.rx_full && $stable(q.rx_byte))
        else $error("pending byte lost");

    code_restart_a: assert property (
        code_go && q.state != ST_SEND && !reset_go |=> MEAS_START_O && q.state == ST_MEAS)
        else $error("complete code did not restart cycle");

    record_tail_a: assert property (
        $rose(TX_VALID_O) && q.tx_last |-> TX_BYTE_O == `CH_LF)
        else $error("record did not end in line feed");

    recall_lamp_a: assert property (
        q.s2.talk && q.prev.talk |=> RECALL_LED_O)
        else $error("recall lamp dark while talking");

    remote_lamp_a: assert property (
        q.s2.remote && q.prev.remote |=> REMOTE_LED_O)
        else $error("remote lamp dark under remote control");
endmodule : remote_port
`default_nettype wire

// >>> tb/bus_ctl_model.sv
`default_nettype none
module bus_ctl_model
(
    input  wire logic             clk_i,
    input  wire logic             tx_valid_i,
    input  wire logic [7:0]       tx_byte_i,
    input  wire logic             rx_busy_i,
    output var  meter_pkg::pins_t pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import meter_pkg::*;
    logic [7:0] got [$];  // Record bytes taken
    int         stall = 0;  // Cycles before each ack
    int         cnt = 0;    // Stall count
    initial pins_o = '0;
    // Listener side of the byte handshake
    always @(posedge clk_i)
    begin
        if (tx_valid_i && !pins_o.ack)
        begin
            if (cnt == stall)
            begin
                got.push_back(tx_byte_i);
                pins_o.ack <= 1'b1;
                cnt <= 0;
            end
            else
                cnt <= cnt + 1;
        end
        else if (!tx_valid_i)
            pins_o.ack <= 1'b0;
    end
    // Addressing lines
    task set_lines(input logic rem, input logic lis, input logic tlk);
        @(posedge clk_i);
        pins_o.remote <= rem;
        pins_o.listen <= lis;
        pins_o.talk   <= tlk;
    endtask : set_lines
    // Group trigger
    task pulse_trig;
        @(posedge clk_i);
        pins_o.trig <= 1'b1;
        repeat (4) @(posedge clk_i);
        pins_o.trig <= 1'b0;
    endtask : pulse_trig
    // One program byte, in keying order
    task send_byte(input logic [7:0] b);
        int n;
        for (n = 0; n < 100 && rx_busy_i; n++) @(posedge clk_i);
        pins_o.dio <= b;
        repeat (3) @(posedge clk_i);
        pins_o.dav <= 1'b1;
        repeat (4) @(posedge clk_i);
        pins_o.dav <= 1'b0;
        pins_o.dio <= ~b;  // Released lines no longer hold the byte
        repeat (3) @(posedge clk_i);
    endtask : send_byte
endmodule : bus_ctl_model
`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
`define CHK(g, e) if (1) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import meter_pkg::*;
    logic clk = 0, rst_b = 0, done = 0;
    apb_req_t apb = '0;
    pins_t pins;
    logic pready, pslverr, srq, tx_valid, rx_busy, start, blank, rem_led, rcl_led, irq;
    logic [31:0] prdata, rdata;
    logic [7:0] tx_byte;
    logic rerr;
    int mismatches = 0, tests_run = 0, starts = 0, blanks = 0, s0, b0, i;
    string cmd = "SR7";
    string rec = " F  00000.000000E+06,\015\012";
    string amp = " F  00000.000000E+06,A +99.9E+\015\012";
    remote_port dut (.CLK_I(clk), .RST_B_I(rst_b), .APB_I(apb), .PINS_I(pins),
        .MEAS_DONE_I(done), .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata),
        .SRQ_O(srq), .TX_VALID_O(tx_valid), .TX_BYTE_O(tx_byte), .RX_BUSY_O(rx_busy),
        .MEAS_START_O(start), .BLANK_O(blank), .REMOTE_LED_O(rem_led),
        .RECALL_LED_O(rcl_led), .IRQ_O(irq));
    bus_ctl_model ctl (.clk_i(clk), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
        .rx_busy_i(rx_busy), .pins_o(pins));
    initial forever #10 clk = ~clk;
    // Pulse counters, sampled mid-cycle
    always @(negedge clk)
    begin
        starts += int'(start);
        blanks += int'(blank);
    end
    task test_done;
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        apb <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk);
        if (pready !== 1'b1)
            wait_out();
        rdata = prdata;
        rerr = pslverr;
        apb <= '0;
    endtask : apb_xfer
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb_xfer(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask : rd_chk
    task wait_out;
        mismatches++;
        $display("CHECK FAILED t=%0t wait ran out", $time);
        test_done();
    endtask : wait_out
    task wait_sig(input logic on_irq, input logic v);
        int n;
        for (n = 0; n < 2000 && (on_irq ? irq : srq) !== v; n++) @(negedge clk);
        if (n == 2000)
            wait_out();
    endtask : wait_sig
    task meas_done;
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
    endtask : meas_done
    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h1C, 32'h4600_6000);
        rd_chk(8'h24, 32'h0);
        `CHK(rerr, 1'b1)
        ctl.set_lines(1'b1, 1'b1, 1'b0);
        repeat (6) @(posedge clk);
        `CHK(rem_led, 1'b1)
        `CHK(rcl_led, 1'b0)
        apb_xfer(1'b1, 8'h10, 32'h1);
        for (i = 0; i < 3; i++)
        begin
            ctl.send_byte(cmd[i]);
            wait_sig(1'b1, 1'b1);
            rd_chk(8'h08, {24'h0, cmd[i]});
            apb_xfer(1'b1, 8'h0C, 32'h1);
            wait_sig(1'b1, 1'b0);
        end
        s0 = starts;
        apb_xfer(1'b1, 8'h04, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(starts, s0 + 1)
        s0 = starts;
        ctl.pulse_trig();
        repeat (4) @(posedge clk);
        `CHK(starts, s0 + 1)
        rd_chk(8'h00, 32'h3);
        apb_xfer(1'b1, 8'h00, 32'h2);
        s0 = starts;
        meas_done();
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        repeat (3) @(posedge clk);
        `CHK(starts, s0 + 1)
        apb_xfer(1'b1, 8'h00, 32'h5);
        meas_done();
        wait_sig(1'b0, 1'b1);
        repeat (30) @(posedge clk);
        `CHK(srq, 1'b1)
        `CHK(ctl.got.size(), 0)
        ctl.stall = 2;
        ctl.set_lines(1'b1, 1'b1, 1'b1);
        repeat (6) @(posedge clk);
        `CHK(rcl_led, 1'b1)
        wait_sig(1'b0, 1'b0);
        `CHK(ctl.got.size(), 23)
        for (i = 0; i < 23; i++)
            `CHK(ctl.got[i], rec[i])
        ctl.set_lines(1'b1, 1'b1, 1'b0);
        repeat (6) @(posedge clk);
        s0 = starts;
        b0 = blanks;
        apb_xfer(1'b1, 8'h04, 32'h2);
        repeat (3) @(posedge clk);
        `CHK(blanks, b0 + 1)
        `CHK(starts, s0 + 1)
        `CHK(rem_led, 1'b1)
        rd_chk(8'h14, 32'h46);
        meas_done();
        repeat (4) @(posedge clk);
        `CHK(srq, 1'b0)
        apb_xfer(1'b1, 8'h00, 32'hD);
        apb_xfer(1'b1, 8'h1C, 32'h4620_6000);
        ctl.set_lines(1'b1, 1'b1, 1'b1);
        repeat (4) @(posedge clk);
        apb_xfer(1'b1, 8'h04, 32'h1);
        meas_done();
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        `CHK(ctl.got.size(), 55)
        for (i = 0; i < 32; i++)
            `CHK(ctl.got[23 + i], amp[i])
        test_done();
    end
endmodule : tb
`default_nettype wire
